// File: rtl/clkgen_pkg.sv
// constants shared by the base clock selector and its source switch
// assumes a 32-bit apb with byte addresses and 12 address bits
package clkgen_pkg;

    // printed register indices; byte address is four times the index
    localparam logic [7:0]  CTRL_IDX       = 8'h1C;
    localparam logic [7:0]  PROG_IDX       = 8'h1E;
    localparam int          ADDR_W         = 12;
    localparam logic [11:0] CTRL_ADDR      = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [11:0] PROG_ADDR      = {2'h0, PROG_IDX, 2'h0};

    // pll control register fields
    localparam int          CTRL_IE_BIT    = 7;
    localparam int          CTRL_FLAG_BIT  = 6;
    localparam int          CTRL_ON_BIT    = 5;
    localparam int          CTRL_BCS_BIT   = 4;
    localparam logic [3:0]  CTRL_UNUSED_RD = 4'hF;

    // programming register fields: multiplier high nibble, range low
    localparam int          MUL_LSB        = 4;
    localparam int          RNG_LSB        = 0;
    localparam int          FIELD_W        = 4;
    localparam logic [3:0]  MUL_RESET      = 4'h6;
    localparam logic [3:0]  RNG_RESET      = 4'h6;
    localparam logic [3:0]  FIELD_ZERO     = 4'h0;
    localparam logic [3:0]  FIELD_ONE      = 4'h1;

    // source edges waited on each side of a source change
    localparam logic [1:0]  SWITCH_EDGES   = 2'h3;

    // switch states, gray along run -> drain -> old -> new -> run
    typedef enum logic [1:0] {
        SW_RUN   = 2'b00,
        SW_DRAIN = 2'b01,
        SW_OLD   = 2'b11,
        SW_NEW   = 2'b10
    } switch_state_e;

endpackage

// File: rtl/clock_source_switch.sv
// glitch-free source switch and divide-by-two for the base clock
// assumes both source clocks are far slower than sys_clk (below a quarter)
`timescale 1ns/10ps
module clock_source_switch (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic crystal_clock,
    input  wire logic vco_clock,
    input  wire logic select_vco,
    output logic      base_clock_out,
    output logic      switch_busy
);

    logic [1:0] xtal_sync_r;
    logic [1:0] xtal_sync_nxt;
    logic [1:0] vco_sync_r;
    logic [1:0] vco_sync_nxt;
    logic       xtal_last_r;
    logic       xtal_last_nxt;
    logic       vco_last_r;
    logic       vco_last_nxt;
    logic       xtal_rise;
    logic       vco_rise;
    logic       cur_vco_r;
    logic       cur_vco_nxt;
    logic       out_r;
    logic       out_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       old_rise;
    logic       new_rise;
    clkgen_pkg::switch_state_e state_r;
    clkgen_pkg::switch_state_e state_nxt;

    // sync stage one feeds only stage two; edges seen on stage two
    always_comb begin
        xtal_sync_nxt = {xtal_sync_r[0], crystal_clock};
        vco_sync_nxt  = {vco_sync_r[0], vco_clock};
        xtal_last_nxt = xtal_sync_r[1];
        vco_last_nxt  = vco_sync_r[1];
    end

    assign xtal_rise = xtal_sync_r[1] & ~xtal_last_r;
    assign vco_rise  = vco_sync_r[1] & ~vco_last_r;
    assign old_rise  = cur_vco_r ? vco_rise : xtal_rise;
    assign new_rise  = cur_vco_r ? xtal_rise : vco_rise;

    // divide by two on the live source; frozen low while switching
    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        cur_vco_nxt = cur_vco_r;
        out_nxt     = out_r;
        case (state_r)
            clkgen_pkg::SW_RUN: begin
                if (old_rise) begin
                    out_nxt = ~out_r;
                end
                if (select_vco != cur_vco_r) begin
                    state_nxt = clkgen_pkg::SW_DRAIN;
                end
            end
            clkgen_pkg::SW_DRAIN: begin
                // finish the high half so the freeze sits low
                if (!out_r) begin
                    state_nxt = clkgen_pkg::SW_OLD;
                    cnt_nxt   = '0;
                end else if (old_rise) begin
                    out_nxt = 1'b0;
                end
            end
            clkgen_pkg::SW_OLD: begin
                // old source gated off; let it run out its edges
                if (cnt_r == clkgen_pkg::SWITCH_EDGES) begin
                    state_nxt = clkgen_pkg::SW_NEW;
                    cnt_nxt   = '0;
                end else if (old_rise) begin
                    cnt_nxt = cnt_r + 2'h1;
                end
            end
            clkgen_pkg::SW_NEW: begin
                // output held static until the new source is counted in
                if (cnt_r == clkgen_pkg::SWITCH_EDGES) begin
                    state_nxt   = clkgen_pkg::SW_RUN;
                    cur_vco_nxt = ~cur_vco_r;
                    cnt_nxt     = '0;
                end else if (new_rise) begin
                    cnt_nxt = cnt_r + 2'h1;
                end
            end
            default: begin
                state_nxt = clkgen_pkg::SW_RUN;
                cnt_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            xtal_sync_r <= '0;
            vco_sync_r  <= '0;
            xtal_last_r <= 1'b0;
            vco_last_r  <= 1'b0;
            cur_vco_r   <= 1'b0;
            out_r       <= 1'b0;
            cnt_r       <= '0;
            state_r     <= clkgen_pkg::SW_RUN;
        end else begin
            xtal_sync_r <= xtal_sync_nxt;
            vco_sync_r  <= vco_sync_nxt;
            xtal_last_r <= xtal_last_nxt;
            vco_last_r  <= vco_last_nxt;
            cur_vco_r   <= cur_vco_nxt;
            out_r       <= out_nxt;
            cnt_r       <= cnt_nxt;
            state_r     <= state_nxt;
        end
    end

    assign base_clock_out = out_r;
    assign switch_busy    = (state_r != clkgen_pkg::SW_RUN);

endmodule // clock_source_switch

// File: rtl/pll_base_clock_selector.sv
// base clock selection, pll control interlocks and programming decode
// assumes an apb master on sys_clk; clocks and lock arrive from pins
`timescale 1ns/10ps
module pll_base_clock_selector (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // clocks, system and analog side
    input  wire logic        crystal_clock,
    input  wire logic        vco_clock,
    input  wire logic        oscillator_enable_in,
    input  wire logic        stop_request,
    input  wire logic        pll_lock_in,
    output logic             base_clock_out,
    output logic             oscillator_run,
    output logic             pll_enable,
    output logic [3:0]       feedback_divider_n,
    output logic [3:0]       vco_range_l,
    output logic             pll_interrupt_request
);

    logic       bcs_r;
    logic       bcs_nxt;
    logic       on_r;
    logic       on_nxt;
    logic       ie_r;
    logic       ie_nxt;
    logic       flag_r;
    logic       flag_nxt;
    logic [3:0] mul_r;
    logic [3:0] mul_nxt;
    logic [3:0] rng_r;
    logic [3:0] rng_nxt;
    logic [1:0] lock_sync_r;
    logic [1:0] lock_sync_nxt;
    logic       lock_last_r;
    logic       lock_last_nxt;
    logic       irq_r;
    logic       irq_nxt;
    logic       osc_r;
    logic       osc_nxt;
    logic       pll_en_r;
    logic       pll_en_nxt;
    logic [3:0] n_r;
    logic [3:0] n_nxt;
    logic [3:0] l_r;
    logic [3:0] l_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        access;
    logic        done;
    logic        wr_ctrl;
    logic        wr_prog;
    logic        rd_ctrl;
    logic        want_bcs;
    logic        want_on;
    logic        lock_toggle;
    logic        range_zero;
    logic        base_clk;
    logic [1:0]  hit;

    // address decode, used for both the answer and the register effects
    function automatic logic [1:0] decode(input logic [11:0] addr);
        decode = {addr == clkgen_pkg::PROG_ADDR,
                  addr == clkgen_pkg::CTRL_ADDR};
    endfunction

    // one wait state: pready rises in the second access cycle
    // decode once into a net; a select on a call result is not portable
    assign access  = psel & penable;
    assign hit     = decode(paddr);
    assign done    = access & pready_r;
    assign wr_ctrl = done & pwrite & hit[0];
    assign wr_prog = done & pwrite & hit[1];
    assign rd_ctrl = done & ~pwrite & hit[0];

    always_comb begin
        pready_nxt  = access & ~pready_r;
        pslverr_nxt = access & ~pready_r & (hit == 2'h0);
        prdata_nxt  = '0;
        if (access & ~pready_r & ~pwrite) begin
            if (hit[0]) begin
                prdata_nxt = {24'h0, ie_r, flag_r, on_r, bcs_r,
                              clkgen_pkg::CTRL_UNUSED_RD};
            end else if (hit[1]) begin
                prdata_nxt = {24'h0, mul_r, rng_r};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // lock input is a pin: two stages before the toggle detector
    assign lock_toggle = lock_sync_r[1] ^ lock_last_r;
    assign range_zero  = (rng_r == clkgen_pkg::FIELD_ZERO);
    assign want_bcs    = pwdata[clkgen_pkg::CTRL_BCS_BIT];
    assign want_on     = pwdata[clkgen_pkg::CTRL_ON_BIT];

    // control and programming registers with their interlocks
    always_comb begin
        lock_sync_nxt = {lock_sync_r[0], pll_lock_in};
        lock_last_nxt = lock_sync_r[1];
        bcs_nxt       = bcs_r;
        on_nxt        = on_r;
        ie_nxt        = ie_r;
        mul_nxt       = mul_r;
        rng_nxt       = rng_r;
        flag_nxt      = flag_r;
        if (wr_ctrl) begin
            ie_nxt = pwdata[clkgen_pkg::CTRL_IE_BIT];
            // both bits moving in one write: neither takes effect
            if ((want_on != on_r) && (want_bcs != bcs_r)) begin
                on_nxt  = on_r;
                bcs_nxt = bcs_r;
            end else begin
                // vco select needs pll on and a nonzero range
                if (want_bcs && on_r && !range_zero) begin
                    bcs_nxt = 1'b1;
                end else if (!want_bcs) begin
                    bcs_nxt = 1'b0;
                end
                // pll stays on while vco drives the base clock
                if (want_on || !bcs_r) begin
                    on_nxt = want_on;
                end
            end
        end
        // locked fields while the pll runs
        if (wr_prog && !on_r) begin
            mul_nxt = pwdata[clkgen_pkg::MUL_LSB +: clkgen_pkg::FIELD_W];
            rng_nxt = pwdata[clkgen_pkg::RNG_LSB +: clkgen_pkg::FIELD_W];
        end
        if (stop_request || range_zero) begin
            bcs_nxt = 1'b0;
        end
        // reading the control register clears the flag; a toggle wins
        if (rd_ctrl) begin
            flag_nxt = 1'b0;
        end
        if (lock_toggle) begin
            flag_nxt = 1'b1;
        end
    end

    // resets: pll on, base from crystal, both fields six
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bcs_r       <= 1'b0;
            on_r        <= 1'b1;
            ie_r        <= 1'b0;
            flag_r      <= 1'b0;
            mul_r       <= clkgen_pkg::MUL_RESET;
            rng_r       <= clkgen_pkg::RNG_RESET;
            lock_sync_r <= '0;
            lock_last_r <= 1'b0;
        end else begin
            bcs_r       <= bcs_nxt;
            on_r        <= on_nxt;
            ie_r        <= ie_nxt;
            flag_r      <= flag_nxt;
            mul_r       <= mul_nxt;
            rng_r       <= rng_nxt;
            lock_sync_r <= lock_sync_nxt;
            lock_last_r <= lock_last_nxt;
        end
    end

    // analog-side controls, all registered
    always_comb begin
        irq_nxt    = flag_r & ie_r;
        osc_nxt    = oscillator_enable_in;
        // range zero shuts the loop down regardless of pll-on
        pll_en_nxt = on_r & oscillator_enable_in & ~range_zero;
        n_nxt      = (mul_r == clkgen_pkg::FIELD_ZERO) ?
                     clkgen_pkg::FIELD_ONE : mul_r;
        l_nxt      = rng_r;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_r    <= 1'b0;
            osc_r    <= 1'b0;
            pll_en_r <= 1'b0;
            n_r      <= clkgen_pkg::MUL_RESET;
            l_r      <= clkgen_pkg::RNG_RESET;
        end else begin
            irq_r    <= irq_nxt;
            osc_r    <= osc_nxt;
            pll_en_r <= pll_en_nxt;
            n_r      <= n_nxt;
            l_r      <= l_nxt;
        end
    end

    // source switch; its output is already a flip-flop
    clock_source_switch u_switch (
        .sys_clk        (sys_clk),
        .rst_b          (rst_b),
        .crystal_clock  (crystal_clock),
        .vco_clock      (vco_clock),
        .select_vco     (bcs_r),
        .base_clock_out (base_clk),
        .switch_busy    ()
    );

    assign base_clock_out        = base_clk;
    assign oscillator_run        = osc_r;
    assign pll_enable            = pll_en_r;
    assign feedback_divider_n    = n_r;
    assign vco_range_l           = l_r;
    assign pll_interrupt_request = irq_r;
    assign prdata                = prdata_r;
    assign pready                = pready_r;
    assign pslverr               = pslverr_r;

endmodule // pll_base_clock_selector

// File: dv/pll_sel_monitor.sv
// port checker for the base clock selector
// assumes one sys_clk domain and an active-low asynchronous reset
`timescale 1ns/10ps
module pll_sel_monitor (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        oscillator_enable_in,
    input wire logic        base_clock_out,
    input wire logic        oscillator_run,
    input wire logic        pll_enable,
    input wire logic [3:0]  feedback_divider_n,
    input wire logic [3:0]  vco_range_l
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    logic       ld_r;
    logic [7:0] ld_d_r;
    logic       ld_nxt;
    logic [7:0] ld_d_nxt;

    // programming write taken while pll-on is known clear
    always_comb begin
        ld_nxt = psel && penable && pready && pwrite && !pll_enable
            && paddr == clkgen_pkg::PROG_ADDR && oscillator_run
            && vco_range_l != 4'h0;
        ld_d_nxt = ld_nxt ? pwdata[7:0] : ld_d_r;
    end

    // capture only; held until the next accepted write
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ld_r   <= 1'b0;
            ld_d_r <= 8'h00;
        end else begin
            ld_r   <= ld_nxt;
            ld_d_r <= ld_d_nxt;
        end
    end

    property p_prog_load;
        ld_r |-> ##[0:2] (vco_range_l == ld_d_r[3:0] && feedback_divider_n
            == (ld_d_r[7:4] == 4'h0 ? 4'h1 : ld_d_r[7:4]));
    endproperty
    a_prog_load : assert property (p_prog_load)
        else $error("programming write not applied");
    property p_mul_nonzero;
        feedback_divider_n != 4'h0;
    endproperty
    a_mul_nonzero : assert property (p_mul_nonzero)
        else $error("multiplier shown as zero");
    property p_range_zero;
        vco_range_l == 4'h0 |-> !pll_enable;
    endproperty
    a_range_zero : assert property (p_range_zero)
        else $error("pll enabled with range zero");
    property p_osc_gate;
        !oscillator_enable_in |=> !oscillator_run && !pll_enable;
    endproperty
    a_osc_gate : assert property (p_osc_gate)
        else $error("oscillator or pll runs without enable");
    property p_reset_vals;
        $rose(rst_b) |-> feedback_divider_n == 4'h6 && vco_range_l == 4'h6;
    endproperty
    a_reset_vals : assert property (p_reset_vals)
        else $error("programming fields not six after reset");
    property p_prog_locked;
        psel && penable && pready && pwrite && pll_enable
            && paddr == clkgen_pkg::PROG_ADDR
            |=> ($stable(feedback_divider_n) && $stable(vco_range_l))[*2];
    endproperty
    a_prog_locked : assert property (p_prog_locked)
        else $error("programming changed while pll on");
    property p_base_spacing;
        $changed(base_clock_out) |=> $stable(base_clock_out)[*3];
    endproperty
    a_base_spacing : assert property (p_base_spacing)
        else $error("base clock toggles too fast");
    property p_apb_wait;
        $rose(penable) && psel |-> !pready ##1 pready;
    endproperty
    a_apb_wait : assert property (p_apb_wait)
        else $error("register access not answered in time");
    property p_unmapped;
        pready |-> pslverr == (paddr != clkgen_pkg::CTRL_ADDR
            && paddr != clkgen_pkg::PROG_ADDR);
    endproperty
    a_unmapped : assert property (p_unmapped)
        else $error("error response wrong for address");

    c_prog_load : cover property (ld_r);
    c_pll_up : cover property ($rose(pll_enable));
    c_unmapped : cover property (pready && pslverr);
endmodule // pll_sel_monitor

bind pll_base_clock_selector pll_sel_monitor u_mon (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .oscillator_enable_in(oscillator_enable_in),
    .base_clock_out(base_clock_out), .oscillator_run(oscillator_run),
    .pll_enable(pll_enable), .feedback_divider_n(feedback_divider_n),
    .vco_range_l(vco_range_l));

// File: dv/pll_far_side.sv
// far-side model: crystal, vco core and lock detector
// assumes oscillator_run and pll_enable come from the selector
`timescale 1ns/10ps
module pll_far_side #(
    parameter int XTAL_P = 100,
    parameter int VCO_P  = 60
) (
    input  wire logic oscillator_run,
    input  wire logic pll_enable,
    output logic      crystal_clock,
    output logic      vco_clock,
    output logic      pll_lock_in
);
    int lock_cnt = 0;

    initial begin
        crystal_clock = 1'b0;
        vco_clock = 1'b0;
        pll_lock_in = 1'b0;
    end

    // crystal stands still low while the oscillator is disabled
    always begin
        #(XTAL_P / 2);
        crystal_clock = oscillator_run ? !crystal_clock : 1'b0;
    end

    // vco runs only while the loop is enabled
    always begin
        #(VCO_P / 2);
        vco_clock = pll_enable ? !vco_clock : 1'b0;
    end

    // lock on the ninth vco rising edge; losing the loop drops lock at once
    always @(posedge vco_clock or negedge pll_enable) begin
        if (!pll_enable) begin
            lock_cnt = 0;
            pll_lock_in = 1'b0;
        end else if (lock_cnt < 8) begin
            lock_cnt = lock_cnt + 1;
        end else begin
            pll_lock_in = 1'b1;
        end
    end
endmodule // pll_far_side

// File: dv/tb_top.sv
// self-checking bench for the base clock selector
// assumes the far-side model and the bound port checker
`timescale 1ns/10ps
module tb_top;
    localparam int XP = 100;
    localparam int VP = 60;
    localparam logic [11:0] CA = clkgen_pkg::CTRL_ADDR;
    localparam logic [11:0] PA = clkgen_pkg::PROG_ADDR;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        oscillator_enable_in = 1'b1;
    logic        stop_request = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        crystal_clock;
    logic        vco_clock;
    logic        pll_lock_in;
    logic        base_clock_out;
    logic        oscillator_run;
    logic        pll_enable;
    logic [3:0]  feedback_divider_n;
    logic [3:0]  vco_range_l;
    logic        pll_interrupt_request;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  v;
    int          ones;
    int          fail_count = 0;
    int          n_tests = 0;

    always #5 sys_clk = !sys_clk;

    pll_base_clock_selector dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .crystal_clock(crystal_clock),
        .vco_clock(vco_clock), .oscillator_enable_in(oscillator_enable_in),
        .stop_request(stop_request), .pll_lock_in(pll_lock_in),
        .base_clock_out(base_clock_out), .oscillator_run(oscillator_run),
        .pll_enable(pll_enable), .feedback_divider_n(feedback_divider_n),
        .vco_range_l(vco_range_l),
        .pll_interrupt_request(pll_interrupt_request));

    pll_far_side #(.XTAL_P(XP), .VCO_P(VP)) far (
        .oscillator_run(oscillator_run), .pll_enable(pll_enable),
        .crystal_clock(crystal_clock), .vco_clock(vco_clock),
        .pll_lock_in(pll_lock_in));

    function automatic logic [31:0] ctrl(input logic ie, input logic on,
                                         input logic sel);
        return {24'h0, ie, 1'b0, on, sel, 4'hF};
    endfunction

    function automatic logic [31:0] prog_out(input logic [7:0] p);
        return {24'h0, (p[7:4] == 4'h0) ? 4'h1 : p[7:4], p[3:0]};
    endfunction

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16) begin
            chk(32'h0, 32'h1, "bus hang");
            summarize();
        end
        @(posedge sys_clk);
    endtask

    // sel 0 watches the interrupt output, sel 1 the lock pin
    task automatic wait_for(input int sel, input logic val, input string m);
        int k;
        logic s;
        s = sel ? pll_lock_in : pll_interrupt_request;
        for (k = 0; k < 300 && s !== val; k++) begin
            @(posedge sys_clk);
            s = sel ? pll_lock_in : pll_interrupt_request;
        end
        chk({31'h0, s}, {31'h0, val}, m);
        if (s !== val) summarize();
    endtask

    // cycles between two base clock rises, one cycle of sync jitter
    task automatic period(input int src_ns, input string m);
        int k;
        int n0;
        int n1;
        logic p;
        n0 = -1;
        n1 = -1;
        p = base_clock_out;
        for (k = 0; k < 600 && n1 < 0; k++) begin
            @(posedge sys_clk);
            if (p === 1'b0 && base_clock_out === 1'b1) begin
                if (n0 < 0) n0 = k;
                else n1 = k;
            end
            p = base_clock_out;
        end
        k = n1 - n0 - 2 * src_ns / 10;
        chk({31'h0, n1 >= 0 && k >= -1 && k <= 1}, 32'h1, m);
        if (n1 < 0) summarize();
    endtask

    initial begin
        void'($urandom(68));
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        chk({24'h0, feedback_divider_n, vco_range_l}, 32'h66, "n l");
        apb(1'b0, CA, 32'h0);
        chk(rd & 32'hFFFF_FFBF, ctrl(0, 1, 0), "ctrl reset");
        apb(1'b0, PA, 32'h0);
        chk(rd, 32'h66, "prog reset");
        apb(1'b1, 12'h074, 32'hFF);
        chk({31'h0, er}, 32'h1, "unmapped err");
        apb(1'b1, PA, 32'h12);
        apb(1'b0, PA, 32'h0);
        chk(rd, 32'h66, "prog locked");
        $display("test reset and locks done");
        apb(1'b1, CA, 32'h90);
        chk({31'h0, er}, 32'h0, "refused write no err");
        apb(1'b0, CA, 32'h0);
        chk(rd & 32'hFFFF_FFBF, ctrl(1, 1, 0), "combined");
        apb(1'b1, CA, 32'hA0);
        wait_for(0, 1'b1, "irq");
        apb(1'b0, CA, 32'h0);
        wait_for(0, 1'b0, "irq clear");
        apb(1'b1, CA, 32'h00);
        apb(1'b1, CA, 32'h10);
        apb(1'b0, CA, 32'h0);
        chk(rd & 32'hFFFF_FFBF, ctrl(0, 0, 0), "sel when off");
        $display("test interlocks done");
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h0F : 8'($urandom);
            apb(1'b1, PA, {24'h0, v});
            apb(1'b0, PA, 32'h0);
            chk({24'h0, feedback_divider_n, vco_range_l}, prog_out(v), "nl");
        end
        $display("test programming done");
        apb(1'b1, PA, 32'h70);
        apb(1'b1, CA, 32'h20);
        apb(1'b1, CA, 32'h30);
        apb(1'b0, CA, 32'h0);
        chk(rd & 32'hFFFF_FFBF, ctrl(0, 1, 0), "range zero");
        chk({31'h0, pll_enable}, 32'h0, "range zero pll");
        apb(1'b1, CA, 32'h0);
        apb(1'b1, PA, 32'h23); // l=3 centres near the model vco
        apb(1'b1, CA, 32'h20);
        wait_for(1, 1'b1, "lock");
        apb(1'b1, CA, 32'h30);
        ones = 0;
        repeat (12) @(posedge sys_clk);
        repeat (16) begin
            @(posedge sys_clk);
            ones += (base_clock_out !== 1'b0);
        end
        chk(ones, 0, "held during switch");
        period(VP, "vco base period");
        apb(1'b1, CA, 32'h10);
        apb(1'b0, CA, 32'h0);
        chk(rd & 32'hFFFF_FFBF, ctrl(0, 1, 1), "off while vco");
        $display("test vco switch done");
        stop_request <= 1'b1;
        @(posedge sys_clk);
        stop_request <= 1'b0;
        apb(1'b0, CA, 32'h0);
        chk(rd & 32'hFFFF_FFBF, ctrl(0, 1, 0), "stop");
        period(XP, "crystal base period");
        oscillator_enable_in <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({30'h0, oscillator_run, pll_enable}, 32'h0, "osc off");
        oscillator_enable_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, oscillator_run}, 32'h1, "osc on");
        $display("test stop and enable done");
        summarize();
    end
endmodule // tb_top
